// file: inc/acr_pkg.sv
package acr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register indices. The byte address of a register is four times its
  // index, so the word index sits on address bits [9:2].
  localparam int unsigned IDX_W      = 8;
  localparam logic [7:0]  IDX_RES_LO = 8'h78;
  localparam logic [7:0]  IDX_RES_HI = 8'h79;
  localparam logic [7:0]  IDX_CSR    = 8'h7A;
  localparam logic [7:0]  IDX_TRIG   = 8'h7B;
  localparam logic [7:0]  IDX_INSEL  = 8'h7C;

  //////////////////////////////////////////////////////////////////////////
  // Field positions of the control/status register.
  localparam int unsigned CSR_ON_BIT    = 7;
  localparam int unsigned CSR_START_BIT = 6;
  localparam int unsigned CSR_AUTO_BIT  = 5;
  localparam int unsigned CSR_DONE_BIT  = 4;
  localparam int unsigned CSR_IE_BIT    = 3;
  localparam int unsigned CSR_DIV_LSB   = 0;
  localparam int unsigned DIV_W         = 3;

  // Field positions of the input select register.
  localparam int unsigned INSEL_REF_LSB  = 6;
  localparam int unsigned REF_W          = 2;
  localparam int unsigned INSEL_LEFT_BIT = 5;
  localparam int unsigned INSEL_CH_LSB   = 0;
  localparam int unsigned CH_W           = 5;

  // Field of the trigger source register.
  localparam int unsigned TRIG_SEL_LSB = 0;
  localparam int unsigned TRIG_W       = 3;
  localparam logic [2:0]  TRIG_FREE    = 3'h0;

  // Reset values of every software visible register.
  localparam logic [7:0] RST_CSR   = 8'h00;
  localparam logic [7:0] RST_INSEL = 8'h00;
  localparam logic [7:0] RST_TRIG  = 8'h00;
  localparam logic [9:0] RST_RES   = 10'h000;

  //////////////////////////////////////////////////////////////////////////
  // Channel select codes.
  localparam logic [4:0] CH_SE_LAST    = 5'h07;
  localparam logic [4:0] CH_DIFF1_LAST = 5'h17;
  localparam logic [4:0] CH_DIFF2_LAST = 5'h1D;
  localparam logic [4:0] CH_BANDGAP    = 5'h1E;
  localparam logic [4:0] CH_GROUND     = 5'h1F;
  localparam logic [1:0] NEG_NONE      = 2'h0;
  localparam logic [1:0] NEG_IN1       = 2'h1;
  localparam logic [1:0] NEG_IN2       = 2'h2;

  // Conversion lengths in converter clock cycles.
  localparam int unsigned FIRST_CYCLES  = 25;
  localparam int unsigned NORMAL_CYCLES = 13;
  localparam int unsigned CNT_W         = 5;

  // Prescaler: shift of the divide ratio for codes 000 and 001.
  localparam logic [2:0] DIV_MIN_SHIFT = 3'h1;
  localparam int unsigned PRE_W        = 7;

  //////////////////////////////////////////////////////////////////////////
  // Routing handed to the analog multiplexer.
  typedef struct packed {
    logic       diff;
    logic       bandgap;
    logic       ground;
    logic       none;
    logic [2:0] pos;
    logic [1:0] neg;
  } acr_route_t;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_NORMAL = 2'b10
  } acr_state_t;

endpackage

// file: rtl/acr_chan_decode.sv
// Turns a channel select code into routing for the analog multiplexer.
module acr_chan_decode (
  // Code in
  input  wire logic [4:0]        code_i,
  // Routing out
  output acr_pkg::acr_route_t    route_o
);

  //////////////////////////////////////////////////////////////////////////
  // Range decodes of the code.
  wire logic is_se    = (code_i <= acr_pkg::CH_SE_LAST);
  wire logic is_none  = (code_i > acr_pkg::CH_SE_LAST) &&
                        (code_i[4] == 1'b0);
  wire logic is_diff1 = code_i[4] && (code_i <= acr_pkg::CH_DIFF1_LAST);
  wire logic is_diff2 = (code_i > acr_pkg::CH_DIFF1_LAST) &&
                        (code_i <= acr_pkg::CH_DIFF2_LAST);

  // Positive input is the low three code bits in every routed case; the
  // internal nodes and the empty codes carry no pin.
  assign route_o.pos     = (is_se || is_diff1 || is_diff2) ?
                           code_i[2:0] : 3'h0;
  assign route_o.neg     = is_diff1 ? acr_pkg::NEG_IN1 :
                           is_diff2 ? acr_pkg::NEG_IN2 :
                           acr_pkg::NEG_NONE;
  assign route_o.diff    = is_diff1 || is_diff2;
  assign route_o.bandgap = (code_i == acr_pkg::CH_BANDGAP);
  assign route_o.ground  = (code_i == acr_pkg::CH_GROUND);
  assign route_o.none    = is_none;

endmodule

// file: rtl/acr_top.sv
module acr_top #(
  parameter int unsigned ADDR_W = 10
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic [ADDR_W-1:0]   wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic                     wb_ack_o,
  output logic [31:0]              wb_dat_o,
  // Analog converter core
  input  wire logic [9:0]          conv_result_i,
  output logic                     converter_on_o,
  output logic                     sample_run_o,
  output logic                     init_conv_o,
  output logic                     conv_clk_o,
  output acr_pkg::acr_route_t      route_o,
  output logic [1:0]               ref_sel_o,
  // Trigger sources and interrupt handshake
  input  wire logic [6:0]          trig_src_i,
  input  wire logic                global_irq_on_i,
  input  wire logic                irq_taken_i,
  output logic                     done_irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Register state.
  logic                       on_q;
  logic                       auto_q;
  logic                       done_q;
  logic                       ie_q;
  logic [2:0]                 div_q;
  logic [1:0]                 ref_q;
  logic                       left_q;
  logic [4:0]                 chan_q;
  logic [2:0]                 trig_sel_q;
  logic [2:0]                 trig_sel_prev_q;
  logic                       trig_prev_q;
  logic [9:0]                 res_q;
  logic                       lock_q;
  logic                       init_done_q;
  acr_pkg::acr_state_t        state_q;
  acr_pkg::acr_state_t        state_d;
  logic [4:0]                 cnt_q;
  logic [6:0]                 pre_q;
  logic                       ack_q;
  logic [31:0]                rdat_q;
  logic                       busy_q;
  logic                       init_q;
  logic                       clk_q;
  logic                       irq_q;
  acr_pkg::acr_route_t        route_q;
  logic [1:0]                 ref_act_q;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode. Only byte lane 0 carries register data; a write without
  // lane 0 is acknowledged but stores nothing.
  wire logic       req      = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic       wr       = req && wb_we_i && wb_sel_i[0];
  wire logic       rd       = req && !wb_we_i;
  wire logic [7:0] idx      = wb_adr_i[2 +: acr_pkg::IDX_W];
  wire logic [7:0] wdat     = wb_dat_i[7:0];
  wire logic       hit_lo   = (idx == acr_pkg::IDX_RES_LO);
  wire logic       hit_hi   = (idx == acr_pkg::IDX_RES_HI);
  wire logic       hit_csr  = (idx == acr_pkg::IDX_CSR);
  wire logic       hit_trig = (idx == acr_pkg::IDX_TRIG);
  wire logic       hit_ins  = (idx == acr_pkg::IDX_INSEL);
  wire logic       wr_csr   = wr && hit_csr;
  wire logic       wr_trig  = wr && hit_trig;
  wire logic       wr_ins   = wr && hit_ins;

  // Fields of a control/status write.
  wire logic       w_on    = wdat[acr_pkg::CSR_ON_BIT];
  wire logic       w_start = wdat[acr_pkg::CSR_START_BIT];
  wire logic       w_done  = wdat[acr_pkg::CSR_DONE_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Channel decode of the software field, latched only at a start.
  acr_pkg::acr_route_t route_new;

  acr_chan_decode u_decode (
    .code_i  (chan_q),
    .route_o (route_new)
  );

  //////////////////////////////////////////////////////////////////////////
  // Prescaler. The divide is a power of two, so the terminal count is a
  // shifted one minus one. Codes 000 and 001 both give divide by two.
  wire logic [2:0] div_shift = (div_q == 3'h0) ?
                               acr_pkg::DIV_MIN_SHIFT : div_q;
  wire logic [7:0] div_span  = 8'h01 << div_shift;
  wire logic [6:0] pre_lim   = div_span[7:1] - 7'h01 + div_span[7:1];
  wire logic [6:0] pre_half  = div_span[7:1];
  wire logic       tick      = (pre_q == pre_lim);
  wire logic [6:0] pre_next  = tick ? 7'h00 : pre_q + 7'h01;

  //////////////////////////////////////////////////////////////////////////
  // Trigger selection. Source 0 is the done flag itself, so free running
  // falls out of the same edge detector as the peripheral sources.
  wire logic [7:0] trig_vec   = {trig_src_i, done_q};
  wire logic       trig_now   = trig_vec[trig_sel_q];
  // Moving onto free running would otherwise see a set flag as an edge.
  wire logic       to_free    = (trig_sel_q == acr_pkg::TRIG_FREE) &&
                                (trig_sel_prev_q != acr_pkg::TRIG_FREE);
  wire logic       trig_edge  = trig_now && !trig_prev_q &&
                                !to_free;

  //////////////////////////////////////////////////////////////////////////
  // Start and stop conditions.
  wire logic idle      = (state_q == acr_pkg::ST_IDLE);
  wire logic on_next   = wr_csr ? w_on : on_q;
  wire logic abort     = !on_next;
  // A start written together with the enable counts; writing zero to
  // the start bit is ignored, and a start while busy changes nothing.
  wire logic sw_start  = wr_csr && w_start && w_on;
  wire logic auto_go   = on_q && auto_q && trig_edge;
  wire logic start_go  = idle && !abort && (sw_start || auto_go);
  wire logic cur_first = (state_q == acr_pkg::ST_FIRST);
  wire logic [4:0] last_cnt = cur_first ?
                              5'(acr_pkg::FIRST_CYCLES - 1) :
                              5'(acr_pkg::NORMAL_CYCLES - 1);
  wire logic finish    = !idle && !abort && tick && (cnt_q == last_cnt);

  // Sequencer next state; an abort wins over everything.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      acr_pkg::ST_IDLE:
      begin
        if (start_go)
          state_d = init_done_q ? acr_pkg::ST_NORMAL :
                                  acr_pkg::ST_FIRST;
      end
      acr_pkg::ST_FIRST,
      acr_pkg::ST_NORMAL:
      begin
        if (abort || finish)
          state_d = acr_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = acr_pkg::ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Result capture. The core hands differential results in offset
  // binary; flipping the top bit gives two's complement.
  wire logic [9:0] res_conv = route_q.diff ?
                              {~conv_result_i[9], conv_result_i[8:0]} :
                              conv_result_i;
  // A lock blocks the update but not the flag, so software still learns
  // that a result was lost while it held the low byte.
  wire logic res_load = finish && !lock_q;
  wire logic done_set = finish;
  wire logic done_clr = (wr_csr && w_done) || irq_taken_i;
  wire logic done_d   = done_set || (done_q && !done_clr);

  // Result bytes as software sees them, following the live adjust bit.
  wire logic [7:0] lo_view = left_q ? {res_q[1:0], 6'h00} :
                             res_q[7:0];
  wire logic [7:0] hi_view = left_q ? res_q[9:2] :
                             {6'h00, res_q[9:8]};
  wire logic [7:0] csr_view = {on_q, !idle, auto_q, done_q, ie_q,
                               div_q};
  wire logic [7:0] ins_view = {ref_q, left_q, chan_q};
  wire logic [7:0] trg_view = {5'h00, trig_sel_q};
  // Unmapped indices answer normally with zero data.
  wire logic [7:0] rd_byte  = hit_lo   ? lo_view  :
                              hit_hi   ? hi_view  :
                              hit_csr  ? csr_view :
                              hit_ins  ? ins_view :
                              hit_trig ? trg_view : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, ack stands one cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software writable fields.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {on_q, auto_q, ie_q, div_q} <= 6'h00;
      {ref_q, left_q, chan_q}     <= acr_pkg::RST_INSEL;
      trig_sel_q                  <= 3'h0;
    end
    else
    begin
      on_q <= on_next;
      if (wr_csr)
      begin
        auto_q <= wdat[acr_pkg::CSR_AUTO_BIT];
        ie_q   <= wdat[acr_pkg::CSR_IE_BIT];
        div_q  <= wdat[acr_pkg::CSR_DIV_LSB +: acr_pkg::DIV_W];
      end
      if (wr_ins)
        {ref_q, left_q, chan_q} <= wdat;
      if (wr_trig)
        trig_sel_q <= wdat[acr_pkg::TRIG_SEL_LSB +: acr_pkg::TRIG_W];
    end
  end

  // Done flag, read lock and trigger edge history. Set beats clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_q          <= 1'b0;
      lock_q          <= 1'b0;
      trig_prev_q     <= 1'b0;
      trig_sel_prev_q <= 3'h0;
      res_q           <= acr_pkg::RST_RES;
    end
    else
    begin
      done_q          <= done_d;
      trig_prev_q     <= trig_now;
      trig_sel_prev_q <= trig_sel_q;
      if (rd && hit_lo)
        lock_q <= 1'b1;
      else if (rd && hit_hi)
        lock_q <= 1'b0;
      if (res_load)
        res_q <= res_conv;
    end
  end

  // Sequencer, cycle counter and prescaler. The prescaler restarts at
  // each start so every conversion lasts exactly its cycle count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q     <= acr_pkg::ST_IDLE;
      cnt_q       <= 5'h00;
      pre_q       <= 7'h00;
      init_done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (start_go)
        cnt_q <= 5'h00;
      else if (tick && !idle)
        cnt_q <= cnt_q + 5'h01;
      pre_q <= (start_go || idle) ? 7'h00 : pre_next;
      if (!on_next)
        init_done_q <= 1'b0;
      else if (start_go)
        init_done_q <= 1'b1;
    end
  end

  // Selection used by the core is frozen for a whole conversion.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      route_q   <= '0;
      ref_act_q <= 2'h0;
    end
    else if (start_go)
    begin
      route_q   <= route_new;
      ref_act_q <= ref_q;
    end
  end

  // Registered outputs to the core and the interrupt controller.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      init_q <= 1'b0;
      clk_q  <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      busy_q <= (state_d != acr_pkg::ST_IDLE);
      init_q <= (state_d == acr_pkg::ST_FIRST);
      clk_q  <= !idle && !finish && !abort &&
                (pre_next >= pre_half);
      irq_q  <= done_d && ie_q && global_irq_on_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output connections, all straight from flip-flops.
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdat_q;
  assign converter_on_o = on_q;
  assign sample_run_o   = busy_q;
  assign init_conv_o    = init_q;
  assign conv_clk_o     = clk_q;
  assign route_o        = route_q;
  assign ref_sel_o      = ref_act_q;
  assign done_irq_o     = irq_q;

endmodule

// file: verif/acr_core_model.sv
module acr_core_model (
  // Clock and conversion state
  input  wire logic       clk_i,
  input  wire logic       sample_run_i,
  // Value that the running conversion measures
  input  wire logic [9:0] value_i,
  output logic      [9:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Outside a run the core shows the inverse, so stale data never matches.
  always_ff @(posedge clk_i)
    result_o <= sample_run_i ? value_i : ~value_i;
endmodule

// file: verif/acr_top_checker.sv
module acr_top_checker (
  // Clock, reset and bus handshake
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic [31:0]         wb_dat_o,
  // Converter side and interrupt
  input wire logic                converter_on_o,
  input wire logic                sample_run_o,
  input wire logic                init_conv_o,
  input wire logic                conv_clk_o,
  input wire acr_pkg::acr_route_t route_o,
  input wire logic [1:0]          ref_sel_o,
  input wire logic                global_irq_on_i,
  input wire logic                done_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // Converter clock rises in the current run. A rise on the finishing
  // edge may fall either side, so one short of the length is tolerated.
  logic [4:0] rises_q;
  logic       ck_q;
  logic       init_q;
  logic [4:0] want;
  assign want = init_q ? 5'h19 : 5'h0D;
  always_ff @(posedge clk_i)
  begin
    ck_q    <= conv_clk_o;
    init_q  <= init_conv_o;
    rises_q <= (rst_i || !sample_run_o) ? 5'h00
             : rises_q + 5'(conv_clk_o && !ck_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus request and normal end of a conversion.
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_finish; sample_run_o ##1 (!sample_run_o && converter_on_o);
  endsequence

  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack is not a single pulse");
  property p_dat; wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 0);
  endproperty
  a_dat: assert property (p_dat)
    else $error("read data outside ack");
  property p_off; !converter_on_o |-> !sample_run_o && !init_conv_o;
  endproperty
  a_off: assert property (p_off)
    else $error("conversion runs while off");
  property p_init; init_conv_o |-> sample_run_o; endproperty
  a_init: assert property (p_init)
    else $error("init flag outside a run");
  property p_len; s_finish |-> (want - rises_q) <= 5'h01; endproperty
  a_len: assert property (p_len)
    else $error("wrong converter clock count");
  property p_route;
    sample_run_o && $past(sample_run_o) |-> $stable(route_o) &&
      $stable(ref_sel_o);
  endproperty
  a_route: assert property (p_route)
    else $error("routing changed in a run");
  property p_irq; done_irq_o |-> $past(global_irq_on_i); endproperty
  a_irq: assert property (p_irq)
    else $error("irq without global enable");
  property p_clk; !sample_run_o && !$past(sample_run_o) |-> !conv_clk_o;
  endproperty
  a_clk: assert property (p_clk)
    else $error("converter clock runs while idle");
  property p_rst;
    $fell(rst_i) |-> !converter_on_o && !done_irq_o && route_o == 0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
endmodule

bind acr_top acr_top_checker u_acr_top_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .converter_on_o(converter_on_o),
  .sample_run_o(sample_run_o), .init_conv_o(init_conv_o),
  .conv_clk_o(conv_clk_o), .route_o(route_o), .ref_sel_o(ref_sel_o),
  .global_irq_on_i(global_irq_on_i), .done_irq_o(done_irq_o)
);

// file: verif/acr_top_test.sv
module acr_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  // Design connections and bench state.
  logic                clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [9:0]          wb_adr_i, conv_result_i, value;
  logic [31:0]         wb_dat_i, wb_dat_o, seed;
  logic [3:0]          wb_sel_i;
  logic                converter_on_o, sample_run_o, init_conv_o;
  logic                conv_clk_o, irq_taken_i, global_irq_on_i;
  logic                done_irq_o, left;
  acr_pkg::acr_route_t route_o;
  logic [1:0]          ref_sel_o;
  logic [6:0]          trig_src_i;
  logic [7:0]          q, lo;
  logic [4:0]          c;
  logic [1:0]          rf, nrf;
  int                  failures, n_compared, cnt, last_len, waited;

  acr_top u_acr_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .conv_result_i(conv_result_i), .converter_on_o(converter_on_o),
    .sample_run_o(sample_run_o), .init_conv_o(init_conv_o),
    .conv_clk_o(conv_clk_o), .route_o(route_o), .ref_sel_o(ref_sel_o),
    .trig_src_i(trig_src_i), .global_irq_on_i(global_irq_on_i),
    .irq_taken_i(irq_taken_i), .done_irq_o(done_irq_o)
  );
  acr_core_model u_acr_core_model (
    .clk_i(clk_i), .sample_run_i(sample_run_o), .value_i(value),
    .result_o(conv_result_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // Random source and expectations.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Differential codes come back with the sign bit flipped.
  function automatic logic [15:0] exp_res(logic [9:0] v, logic [4:0] k,
                                          logic l);
    logic [9:0] r;
    r = (k[4] && k < 5'h1E) ? v ^ 10'h200 : v;
    return l ? {r, 6'h00} : {6'h00, r};
  endfunction
  function automatic int dv(int d);
    return d < 2 ? 2 : 1 << d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Classic bus cycle: hold everything until ack is sampled high.
  task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
    wb_adr_i <= {i, 2'h0};
    wb_dat_i <= {24'h0, d};
    wb_we_i  <= w;
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(i, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] i);
    bus(i, 1'b0, 8'h00);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // Waits, bounded, until the run flag reaches a level.
  task automatic wait_for(input logic lvl);
    waited = 0;
    while (sample_run_o !== lvl && waited < 20000)
    begin
      @(posedge clk_i);
      waited++;
    end
    // A wait that runs out is a mismatch in its own right.
    if (waited >= 20000)
      failures++;
    @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, run length monitor and watchdog.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cnt <= sample_run_o ? cnt + 1 : 0;
    if (!sample_run_o && cnt != 0)
      last_len <= cnt;
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    seed = 32'h0000E706;
    rst_i <= 1'b1;
    wb_sel_i <= 4'hF;
    {wb_we_i, wb_cyc_i, wb_stb_i, irq_taken_i, global_irq_on_i} <= 5'h00;
    {wb_adr_i, wb_dat_i, value} <= 52'h0;
    trig_src_i <= 7'(rnd()) & 7'h7B;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h78 + 8'(i));
      chk(q, 8'h00);
    end
    wr(8'h10, 8'hFF);
    rd(8'h10);
    chk(q, 8'h00);
    $display("reset test done");
    wr(8'h7C, 8'h00);
    rf = 2'h0;
    for (int i = 0; i < 32; i++)
    begin
      c = 5'(i);
      value <= 10'(rnd());
      left = 1'(rnd());
      nrf = 2'(rnd());
      wr(8'h7A, 8'hC0);
      wr(8'h7C, {nrf, left, 5'(i + 1)});
      rd(8'h7A);
      chk(q[7:6], 2'h3);
      chk(init_conv_o, i == 0);
      chk(ref_sel_o, rf);
      rf = nrf;
      chk(route_o[8:5], {c[4] && c < 5'h1E, c == 5'h1E, c == 5'h1F,
                         c[4:3] == 2'h1});
      if (c < 5'h08 || (c[4] && c < 5'h1E))
        chk(route_o[4:0], {c[2:0], c[4] ? (c[3] ? acr_pkg::NEG_IN2 :
            acr_pkg::NEG_IN1) : acr_pkg::NEG_NONE});
      wait_for(1'b0);
      chk(last_len, i == 0 ? 50 : 26);
      rd(8'h78);
      lo = q;
      rd(8'h79);
      chk({q, lo}, exp_res(value, c, left));
      rd(8'h7A);
      chk(q, 8'h90);
      wr(8'h7A, 8'h90);
    end
    $display("channel test done");
    wr(8'h7C, 8'h00);
    value <= 10'h2A5;
    wr(8'h7A, 8'hC0);
    wait_for(1'b0);
    rd(8'h78);
    value <= 10'h15A;
    wr(8'h7A, 8'hD0);
    wait_for(1'b0);
    rd(8'h79);
    chk(q, 8'h02);
    rd(8'h78);
    chk(q, 8'hA5);
    wr(8'h7C, 8'h20);
    rd(8'h79);
    chk(q, 8'hA9);
    global_irq_on_i <= 1'b1;
    wr(8'h7A, 8'hD8);
    wait_for(1'b0);
    chk(done_irq_o, 1'b1);
    wr(8'h7A, 8'h88);
    chk(done_irq_o, 1'b1);
    irq_taken_i <= 1'b1;
    @(posedge clk_i);
    irq_taken_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(done_irq_o, 1'b0);
    wr(8'h7A, 8'hC8);
    wait_for(1'b0);
    wr(8'h7A, 8'h98);
    rd(8'h7A);
    chk(q, 8'h88);
    $display("lock and flag test done");
    for (int d = 0; d < 8; d++)
    begin
      wr(8'h7A, 8'h10);
      wr(8'h7A, 8'hC0 | 8'(d));
      wait_for(1'b0);
      chk(last_len, 25 * dv(d));
      wr(8'h7A, 8'hD0 | 8'(d));
      wait_for(1'b0);
      chk(last_len, 13 * dv(d));
    end
    $display("prescaler test done");
    wr(8'h7A, 8'h10);
    wr(8'h7B, 8'h03);
    wr(8'h7A, 8'hA0);
    trig_src_i <= trig_src_i | 7'h04;
    wait_for(1'b1);
    wait_for(1'b0);
    chk(last_len, 50);
    // A low old source makes the set flag look like an edge on the switch.
    trig_src_i <= trig_src_i & 7'h7B;
    wr(8'h7B, 8'h00);
    repeat (6) @(posedge clk_i);
    chk(sample_run_o, 1'b0);
    wr(8'h7A, 8'hF0);
    wait_for(1'b0);
    wait_for(1'b1);
    chk(waited < 4, 1'b1);
    $display("trigger test done");
    wr(8'h7A, 8'h10);
    wr(8'h7A, 8'hC0);
    wr(8'h7A, 8'h00);
    chk(sample_run_o, 1'b0);
    chk(converter_on_o, 1'b0);
    repeat (60) @(posedge clk_i);
    rd(8'h7A);
    chk(q, 8'h00);
    $display("abort test done");
    complete_run();
  end
endmodule
